// ---- hw/dac_cmd_layer.sv ----
// Command, pointer and status access layer for two async channels
`include "dac_regs.svh"
`default_nettype none
module dac_cmd_layer (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Host access strobes (synchronous to mclk)
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  input  wire dac_pkg::dac_acc_s   acc,
  // Data bus snoop for return opcode
  input  wire logic                fetch_stb,
  input  wire logic [7:0]          fetch_data,
  // Interrupt acknowledge sets under-service
  input  wire logic                int_ack,
  // Bit clocks from the line side
  input  wire logic [1:0]          transmit_bit_clock,
  input  wire logic [1:0]          receive_bit_clock,
  // Channel events from the data path
  input  wire logic [1:0]          tx_empty_ev,
  input  wire logic [1:0]          rx_char_ev,
  input  wire logic [7:0]          status_a,
  input  wire logic [7:0]          status_b,
  input  wire logic [7:0]          rx_err_a,
  input  wire logic [7:0]          rx_err_b,
  input  wire logic [2:0]          pend_code,
  input  wire logic                int_pending,
  // Daisy chain
  input  wire logic                chain_enable_in,
  output logic                     chain_enable_out,
  // Read data and wait/ready
  output logic [7:0]               rd_data,
  output logic                     wait_ready,
  // Decoded configuration per channel
  output dac_pkg::dac_fmt_s        fmt_a,
  output dac_pkg::dac_fmt_s        fmt_b,
  output logic [1:0]               chan_reset,
  output logic [7:0]               vector_out
);
  // Register state, index 0 is channel A
  logic [2:0]  ptr_reg [2];
  logic [2:0]  ptr_next [2];
  logic [7:0]  intm_reg [2];
  logic [7:0]  intm_next [2];
  logic [7:0]  rxc_reg [2];
  logic [7:0]  rxc_next [2];
  logic [7:0]  fmt_reg [2];
  logic [7:0]  fmt_next [2];
  logic [7:0]  txc_reg [2];
  logic [7:0]  txc_next [2];
  logic [7:0]  vec_reg;
  logic [7:0]  vec_next;
  logic        ius_reg;
  logic        ius_next;
  logic        prefix_reg;
  logic        prefix_next;
  logic [7:0]  rd_reg;
  logic [7:0]  rd_next;
  logic [1:0]  crst_reg;
  logic [1:0]  crst_next;
  logic        wr_ret;
  logic        op_ret;
  logic [1:0]  tx_fall;
  logic [1:0]  rx_rise;
  logic [1:0]  tx_hit;
  logic [1:0]  rx_hit;
  logic [1:0]  tx_late;
  logic [1:0]  rx_late;
  logic        wr_ev_reg;
  logic        wr_ev_next;
  logic [7:0]  vout_reg;
  logic [7:0]  vout_next;

  // Delay depths left after the two synchroniser stages
  localparam int TX_DEPTH = `DAC_TX_LAT_CYC - 2;
  localparam int RX_DEPTH = `DAC_RX_LAT_CYC - 2;

  // Each delay line needs two stages or it cannot shift
  if (TX_DEPTH < 2 || RX_DEPTH < 2) begin : g_lat_chk
    $error("wait/ready latency leaves too few delay stages");
  end

  // Stop and multiplier decode, shared by both channels
  function automatic dac_pkg::dac_fmt_s fmt_decode(input logic [7:0] f);
    dac_pkg::dac_fmt_s d;
    d.par_en   = f[`DAC_FMT_PAR_EN];
    d.par_even = f[`DAC_FMT_PAR_EVEN];
    d.stop     = dac_pkg::dac_stop_e'(f[`DAC_FMT_STOP_LSB +: 2]);
    case (f[`DAC_FMT_CLK_LSB +: 2])
      2'b00:   d.mult = 7'h01;
      2'b01:   d.mult = 7'h10;
      2'b10:   d.mult = 7'h20;
      2'b11:   d.mult = 7'h40;
      // Two-bit field; the default only keeps the case complete
      default: d.mult = 7'h01;
    endcase
    return d;
  endfunction

  // Vector with bits 3:1 replaced by pending source code when sav is set
  function automatic logic [7:0] vec_modify(input logic [7:0] v,
                                            input logic       sav,
                                            input logic [2:0] code);
    return sav ? {v[7:4], code, v[0]} : v;
  endfunction

  // Bit clock edge finders, one per bit clock, two per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_clk
      dac_edge_sync u_tx (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (transmit_bit_clock[g]),
        .level    (),
        .rise     (),
        .fall     (tx_fall[g])
      );
      dac_edge_sync u_rx (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (receive_bit_clock[g]),
        .level    (),
        .rise     (rx_rise[g]),
        .fall     ()
      );
      // An edge counts only when the data path flags the event
      assign tx_hit[g] = tx_fall[g] & tx_empty_ev[g];
      assign rx_hit[g] = rx_rise[g] & rx_char_ev[g];
      // Sync takes 2 cycles; delay tops it up inside the window
      // An edge seen mid-cycle adds up to one more period of skew
      dac_delay_line #(.DEPTH(TX_DEPTH)) u_txd (
        .mclk   (mclk),
        .rst    (rst),
        .ev_in  (tx_hit[g]),
        .ev_out (tx_late[g])
      );
      dac_delay_line #(.DEPTH(RX_DEPTH)) u_rxd (
        .mclk   (mclk),
        .rst    (rst),
        .ev_in  (rx_hit[g]),
        .ev_out (rx_late[g])
      );
    end
  endgenerate

  // Return detection by command or by bus snoop
  // Only a byte at the command pointer counts as a command
  assign wr_ret = wr_stb & acc.ctl_sel & ~acc.chan_b &
                  (ptr_reg[0] == `DAC_PTR_CMD) &
                  (acc.data[5:3] == `DAC_CMD_RETURN);
  assign op_ret = fetch_stb & prefix_reg &
                  (fetch_data == `DAC_OP_RETURN);

  // Snoop, under-service latch and vector
  always_comb begin
    // Prefix byte must come directly before the return byte
    prefix_next = prefix_reg;
    if (fetch_stb) begin
      prefix_next = (fetch_data == `DAC_OP_PREFIX);
    end
    ius_next = ius_reg;
    // A return clears the latch; an acknowledge in the same cycle wins
    // because it opens the next service period
    if (op_ret | wr_ret) begin
      ius_next = 1'b0;
    end
    if (int_ack) begin
      ius_next = 1'b1;
    end
    // Vector register lives in channel B only
    vec_next = vec_reg;
    if (wr_stb & acc.ctl_sel & acc.chan_b & ptr_reg[1] == `DAC_PTR_VECTOR) begin
      vec_next = acc.data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      prefix_reg <= 1'b0;
      ius_reg    <= 1'b0;
      vec_reg    <= `DAC_RESET_BYTE;
    end else begin
      prefix_reg <= prefix_next;
      ius_reg    <= ius_next;
      vec_reg    <= vec_next;
    end
  end

  // Pointer and write registers per channel
  always_comb begin
    // Reset pulse lasts one cycle; the data path clears its own state
    crst_next = 2'b00;
    for (int c = 0; c < 2; c++) begin
      ptr_next[c]  = ptr_reg[c];
      intm_next[c] = intm_reg[c];
      rxc_next[c]  = rxc_reg[c];
      fmt_next[c]  = fmt_reg[c];
      txc_next[c]  = txc_reg[c];
      // Channel select and control/data route the access
      if (acc.chan_b == c[0] && acc.ctl_sel && (wr_stb || rd_stb)) begin
        if (wr_stb && ptr_reg[c] == `DAC_PTR_CMD) begin
          // Single byte carries command and pointer
          if (acc.data[5:3] == `DAC_CMD_CHAN_RST) begin
            ptr_next[c]  = `DAC_PTR_CMD;
            crst_next[c] = 1'b1;
            intm_next[c] = `DAC_RESET_BYTE;
            rxc_next[c]  = `DAC_RESET_BYTE;
            txc_next[c]  = `DAC_RESET_BYTE;
          end else begin
            ptr_next[c] = acc.data[2:0];
          end
        end else begin
          if (wr_stb) begin
            case (ptr_reg[c])
              `DAC_PTR_INTMODE: intm_next[c] = acc.data;
              `DAC_PTR_RXCTL:   rxc_next[c]  = acc.data;
              `DAC_PTR_FORMAT:  fmt_next[c]  = acc.data;
              `DAC_PTR_TXCTL:   txc_next[c]  = acc.data;
              default:          ;
            endcase
          end
          // Any access at a nonzero pointer falls back, reads included
          ptr_next[c] = `DAC_PTR_CMD;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        ptr_reg[c]  <= `DAC_PTR_CMD;
        intm_reg[c] <= `DAC_RESET_BYTE;
        rxc_reg[c]  <= `DAC_RESET_BYTE;
        fmt_reg[c]  <= `DAC_RESET_BYTE;
        txc_reg[c]  <= `DAC_RESET_BYTE;
      end
      crst_reg <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        ptr_reg[c]  <= ptr_next[c];
        intm_reg[c] <= intm_next[c];
        rxc_reg[c]  <= rxc_next[c];
        fmt_reg[c]  <= fmt_next[c];
        txc_reg[c]  <= txc_next[c];
      end
      crst_reg <= crst_next;
    end
  end

  // Read mux; reads are registered so data holds between strobes
  always_comb begin
    rd_next = rd_reg;
    if (rd_stb && acc.ctl_sel) begin
      // Pointer 2 exists in channel B only; channel A reads zero there
      case (ptr_reg[acc.chan_b])
        3'h1:    rd_next = acc.chan_b ? rx_err_b : rx_err_a;
        3'h2:    rd_next = acc.chan_b ?
                   vec_modify(vec_reg, intm_reg[1][`DAC_IM_SAV_BIT],
                              pend_code) : 8'h00;
        default: rd_next = acc.chan_b ? status_b : status_a;
      endcase
    end
  end
  // Vector output registered so the pin never glitches with pend_code
  always_comb begin
    vout_next = vec_modify(vec_reg, intm_reg[1][`DAC_IM_SAV_BIT],
                           pend_code);
  end

  // Wait/ready pulse stretched until the next host access
  always_comb begin
    wr_ev_next = wr_ev_reg;
    if ((|tx_late) || (|rx_late)) begin
      wr_ev_next = 1'b1;
    end else if (wr_stb || rd_stb) begin
      wr_ev_next = 1'b0;
    end
  end
  // Registers for read data, wait/ready and the vector pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_reg    <= 8'h00;
      wr_ev_reg <= 1'b0;
      vout_reg  <= 8'h00;
    end else begin
      rd_reg    <= rd_next;
      wr_ev_reg <= wr_ev_next;
      vout_reg  <= vout_next;
    end
  end

  // Outputs
  assign rd_data          = rd_reg;
  assign wait_ready       = wr_ev_reg & (intm_reg[0][`DAC_IM_WR_MODE] |
                                         intm_reg[1][`DAC_IM_WR_MODE]);
  // Chain stays combinational so a long chain settles within one access
  assign chain_enable_out = chain_enable_in & ~ius_reg & ~int_pending;
  assign fmt_a            = fmt_decode(fmt_reg[0]);
  assign fmt_b            = fmt_decode(fmt_reg[1]);
  assign chan_reset       = crst_reg;
  assign vector_out       = vout_reg;
endmodule
`default_nettype wire

// ---- hw/dac_regs.svh ----
// Constants for the dual-channel async command layer
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH
`define DAC_PTR_CMD       3'h0
`define DAC_PTR_INTMODE   3'h1
`define DAC_PTR_VECTOR    3'h2
`define DAC_PTR_RXCTL     3'h3
`define DAC_PTR_FORMAT    3'h4
`define DAC_PTR_TXCTL     3'h5
`define DAC_CMD_CHAN_RST  3'h3
`define DAC_CMD_RETURN    3'h7
`define DAC_OP_PREFIX     8'hED
`define DAC_OP_RETURN     8'h4D
`define DAC_FMT_PAR_EN    0
`define DAC_FMT_PAR_EVEN  1
`define DAC_FMT_STOP_LSB  2
`define DAC_FMT_CLK_LSB   6
`define DAC_IM_SAV_BIT    2
`define DAC_IM_WR_MODE    6
`define DAC_TX_LAT_CYC    6
`define DAC_RX_LAT_CYC    11
`define DAC_RESET_BYTE    8'h00
`endif

// ---- hw/dac_pkg.sv ----
// Types shared by the dual-channel async command layer
`default_nettype none
package dac_pkg;
  typedef enum logic [1:0] {
    DAC_STOP_NONE = 2'b00,
    DAC_STOP_ONE  = 2'b01,
    DAC_STOP_ONEH = 2'b10,
    DAC_STOP_TWO  = 2'b11
  } dac_stop_e;
  typedef struct packed {
    logic       chan_b;
    logic       ctl_sel;
    logic [7:0] data;
  } dac_acc_s;
  typedef struct packed {
    logic [6:0] mult;
    dac_stop_e  stop;
    logic       par_en;
    logic       par_even;
  } dac_fmt_s;
endpackage
`default_nettype wire

// ---- hw/dac_edge_sync.sv ----
// Two-flop synchroniser with edge detection for bit clocks and pins
`default_nettype none
module dac_edge_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  // Stage 0 feeds only stage 1; edges look at stages 1 and 2
  always_comb begin
    sh_next = {sh_reg[1:0], async_in};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sh_reg <= 3'h0;
    end else begin
      sh_reg <= sh_next;
    end
  end
  assign level = sh_reg[1];
  assign rise  = sh_reg[1] & ~sh_reg[2];
  assign fall  = ~sh_reg[1] & sh_reg[2];
endmodule
`default_nettype wire

// ---- hw/dac_delay_line.sv ----
// Fixed-latency event delay used for wait/ready timing
`default_nettype none
module dac_delay_line #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Event in and delayed event out
  input  wire logic ev_in,
  output logic      ev_out
);
  logic [DEPTH-1:0] dl_reg;
  logic [DEPTH-1:0] dl_next;
  // A single stage would leave no shift path, so refuse it at elaboration
  if (DEPTH < 2) begin : g_depth_chk
    $error("DEPTH must be at least 2");
  end
  // Shift register keeps several events in flight
  always_comb begin
    dl_next = {dl_reg[DEPTH-2:0], ev_in};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      dl_reg <= '0;
    end else begin
      dl_reg <= dl_next;
    end
  end
  assign ev_out = dl_reg[DEPTH-1];
endmodule
`default_nettype wire

// ---- bench/dac_cmd_layer_properties.sv ----
// Port-level checker for the dual-channel command layer
`default_nettype none
module dac_cmd_layer_properties (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // Host side
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire dac_pkg::dac_acc_s acc,
  input wire logic [7:0]        status_a,
  input wire logic [7:0]        rx_err_a,
  input wire logic [7:0]        rd_data,
  input wire dac_pkg::dac_fmt_s fmt_a,
  input wire logic [1:0]        chan_reset,
  // Line and chain side
  input wire logic [1:0]        transmit_bit_clock,
  input wire logic [1:0]        receive_bit_clock,
  input wire logic [1:0]        tx_empty_ev,
  input wire logic [1:0]        rx_char_ev,
  input wire logic              int_pending,
  input wire logic              chain_enable_in,
  input wire logic              chain_enable_out,
  input wire logic              wait_ready
);
  logic [2:0] ptr_reg, ptr_next;
  logic       wm_reg, wm_next, wr_a, rd_a, fw, crst;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Channel A strobes; fw marks a format word
  assign wr_a = wr_stb && acc.ctl_sel && !acc.chan_b;
  assign rd_a = rd_stb && acc.ctl_sel && !acc.chan_b;
  assign fw   = wr_a && ptr_reg == 3'h4;
  assign crst = wr_a && ptr_reg == 3'h0 && acc.data[5:3] == 3'h3;
  // Pointer mirror; channel reset also drops the ready mode to be safe
  always_comb begin
    ptr_next = ptr_reg;
    wm_next  = wm_reg;
    if (wr_a && ptr_reg == 3'h1) wm_next = acc.data[6];
    if (wr_a || rd_a) ptr_next = (wr_a && ptr_reg == 3'h0 && !crst) ?
                                 acc.data[2:0] : 3'h0;
    if (rst || crst) wm_next = 1'b0;
    if (rst) ptr_next = 3'h0;
  end
  always_ff @(posedge mclk) begin
    ptr_reg <= ptr_next;
    wm_reg  <= wm_next;
  end
  a_chain_hold: assert property (
    (int_pending || !chain_enable_in) |-> !chain_enable_out)
    else $error("chain enable passed while busy");
  a_stop_field: assert property (
    fw |=> fmt_a.stop == $past(acc.data[3:2]))
    else $error("stop field not stored");
  a_clock_mult: assert property (
    fw |=> fmt_a.mult == (($past(acc.data[7:6]) == 2'h0) ? 7'h01 :
                          7'h01 << (3 + $past(acc.data[7:6]))))
    else $error("clock multiplier wrong");
  a_parity_bits: assert property (
    fw |=> fmt_a.par_en == $past(acc.data[0]) &&
           fmt_a.par_even == $past(acc.data[1]))
    else $error("parity bits wrong");
  a_chan_reset: assert property (
    crst |=> chan_reset[0]) else $error("channel reset not decoded");
  a_primary_read: assert property (
    rd_a && ptr_reg == 3'h0 |=> rd_data == $past(status_a))
    else $error("primary status wrong");
  a_special_read: assert property (
    rd_a && ptr_reg == 3'h1 |=> rd_data == $past(rx_err_a))
    else $error("special receive status wrong");
  a_ptr_return: assert property (
    rd_a && ptr_reg != 3'h0 ##1 rd_a |=> rd_data == $past(status_a))
    else $error("pointer did not return");
  a_tx_ready: assert property (
    wm_reg && !wait_ready && tx_empty_ev[0] &&
    $fell(transmit_bit_clock[0]) |-> ##[4:9] wait_ready)
    else $error("transmit ready late");
  a_rx_ready: assert property (
    wm_reg && !wait_ready && rx_char_ev[0] &&
    $rose(receive_bit_clock[0]) |-> ##[9:13] wait_ready)
    else $error("receive ready late");
  // Main scenarios
  c_format: cover property (fw);
  c_special: cover property (rd_a && ptr_reg == 3'h1);
  c_tx: cover property (wm_reg && $fell(transmit_bit_clock[0]));
endmodule
bind dac_cmd_layer dac_cmd_layer_properties i_dac_cmd_layer_properties (.*);
`default_nettype wire

// ---- bench/dac_line_model.sv ----
// Line-side bit clock source; clocks idle low between frames
`default_nettype none
module dac_line_model (
  // Bit clocks, bit 0 is channel A
  output logic [1:0] transmit_bit_clock,
  output logic [1:0] receive_bit_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    transmit_bit_clock = 2'h0;
    receive_bit_clock  = 2'h0;
  end
  // One 40 ns high pulse, off the system clock phase; ends on the fall
  task automatic tx_fall(input int ch);
    #3 transmit_bit_clock[ch] = 1'b1;
    #40 transmit_bit_clock[ch] = 1'b0;
  endtask
  // Returns at the rise so the caller can time from it
  task automatic rx_rise(input int ch);
    #3 receive_bit_clock[ch] = 1'b1;
    fork
      #40 receive_bit_clock[ch] = 1'b0;
    join_none
  endtask
endmodule
`default_nettype wire

// ---- bench/dac_cmd_layer_test.sv ----
// Self-checking bench for the dual-channel command layer
`default_nettype none
module dac_cmd_layer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk, rst, wr_stb, rd_stb, fetch_stb, int_ack;
  logic              int_pending, chain_enable_in, chain_enable_out;
  logic              wait_ready;
  dac_pkg::dac_acc_s acc;
  dac_pkg::dac_fmt_s fmt_a, fmt_b;
  logic [7:0]        fetch_data, status_a, status_b, rx_err_a, rx_err_b;
  logic [7:0]        rd_data, v, vector_out;
  logic [1:0]        tx_empty_ev, rx_char_ev, chan_reset;
  logic [1:0]        transmit_bit_clock, receive_bit_clock;
  logic [2:0]        pend_code;
  int                n_errors, samples_checked, n;
  always #5 mclk = ~mclk;
  dac_cmd_layer i_dac_cmd_layer (.mclk, .rst, .wr_stb, .rd_stb, .acc,
    .fetch_stb, .fetch_data, .int_ack, .transmit_bit_clock,
    .receive_bit_clock, .tx_empty_ev, .rx_char_ev, .status_a, .status_b,
    .rx_err_a, .rx_err_b, .pend_code, .int_pending, .chain_enable_in,
    .chain_enable_out, .rd_data, .wait_ready, .fmt_a, .fmt_b,
    .chan_reset, .vector_out);
  dac_line_model i_dac_line_model (.transmit_bit_clock, .receive_bit_clock);
  task automatic chk(input string nm, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One host access; strobes stay up until the next op or idle
  task automatic op(input logic w, r, b, input logic [7:0] d);
    @(posedge mclk);
    wr_stb <= w;
    rd_stb <= r;
    acc    <= '{chan_b: b, ctl_sel: 1'b1, data: d};
  endtask
  task automatic idle;
    @(posedge mclk);
    {wr_stb, rd_stb, fetch_stb, int_ack} <= 4'h0;
    #1;
  endtask
  task automatic pulse(input logic snoop, input logic [7:0] d);
    @(posedge mclk);
    fetch_stb  <= snoop;
    int_ack    <= !snoop;
    fetch_data <= d;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for ready, counted in system clocks
  task automatic expect_ready(input string nm, input int lo, hi);
    n = 0;
    while (wait_ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(nm, 8'h01, 8'(n >= lo && n <= hi));
    if (n == 20) report_and_stop;
  endtask
  function automatic logic [7:0] exp_mult(input logic [1:0] c);
    return (c == 2'h0) ? 8'h01 : 8'h01 << (3 + c);
  endfunction
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {wr_stb, rd_stb, fetch_stb, int_ack, int_pending} = 5'h00;
    {tx_empty_ev, rx_char_ev, pend_code} = 7'h00;
    acc = '0;
    fetch_data = 8'h00;
    chain_enable_in = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(60793));
    {status_a, status_b, rx_err_a, rx_err_b} = $urandom;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    idle;
    chk("fmt reset", exp_mult(2'h0), 8'(fmt_a.mult));
    // Every clock and stop code, random parity bits
    for (int i = 0; i < 16; i++) begin
      v = {i[3:2], 2'h0, i[1:0], 2'($urandom)};
      op(1'b1, 1'b0, 1'b0, 8'h04);
      op(1'b1, 1'b0, 1'b0, v);
      idle;
      chk("mult", exp_mult(v[7:6]), 8'(fmt_a.mult));
      chk("stop", 8'(v[3:2]), 8'(fmt_a.stop));
      chk("parity", 8'(v[1:0]), 8'({fmt_a.par_even, fmt_a.par_en}));
    end
    op(1'b1, 1'b0, 1'b1, 8'h04);
    op(1'b1, 1'b0, 1'b1, 8'hC4);
    idle;
    chk("mult b", exp_mult(2'h3), 8'(fmt_b.mult));
    chk("stop b", 8'h01, 8'(fmt_b.stop));
    $display("test format done");
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    chk("primary", status_a, rd_data);
    op(1'b1, 1'b0, 1'b0, 8'h01);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    chk("back", status_a, rd_data);
    op(1'b1, 1'b0, 1'b0, 8'h01);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    chk("special", rx_err_a, rd_data);
    op(1'b1, 1'b0, 1'b0, 8'h02);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    chk("vector a", 8'h00, rd_data);
    $display("test reads done");
    // Vector with and without status affecting it
    v = 8'($urandom);
    pend_code <= 3'($urandom);
    for (int s = 0; s < 2; s++) begin
      op(1'b1, 1'b0, 1'b1, 8'h02);
      op(1'b1, 1'b0, 1'b1, v);
      op(1'b1, 1'b0, 1'b1, 8'h01);
      op(1'b1, 1'b0, 1'b1, s ? 8'h04 : 8'h00);
      op(1'b1, 1'b0, 1'b1, 8'h02);
      op(1'b0, 1'b1, 1'b1, 8'h00);
      idle;
      chk("vector", s ? {v[7:4], pend_code, v[0]} : v, rd_data);
      chk("vector pin", s ? {v[7:4], pend_code, v[0]} : v,
          vector_out);
    end
    $display("test vector done");
    op(1'b1, 1'b0, 1'b0, 8'h18);
    idle;
    chk("chan reset", 8'h01, 8'(chan_reset));
    op(1'b1, 1'b0, 1'b0, 8'h04);
    idle;
    rst <= 1'b1;
    idle;
    rst <= 1'b0;
    op(1'b1, 1'b0, 1'b0, 8'h01);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    chk("reset ptr", rx_err_a, rd_data);
    $display("test resets done");
    pulse(1'b0, 8'h00);
    idle;
    chk("busy", 8'h00, 8'(chain_enable_out));
    op(1'b1, 1'b0, 1'b0, 8'h38);
    idle;
    idle;
    chk("cmd return", 8'h01, 8'(chain_enable_out));
    pulse(1'b0, 8'h00);
    pulse(1'b1, 8'hED);
    pulse(1'b1, 8'h4D);
    idle;
    idle;
    chk("op return", 8'h01, 8'(chain_enable_out));
    int_pending <= 1'b1;
    idle;
    chk("pending", 8'h00, 8'(chain_enable_out));
    int_pending <= 1'b0;
    $display("test return done");
    op(1'b1, 1'b0, 1'b0, 8'h01);
    op(1'b1, 1'b0, 1'b0, 8'h40);
    idle;
    tx_empty_ev <= 2'h1;
    i_dac_line_model.tx_fall(0);
    expect_ready("tx ready", 5, 10);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    idle;
    rx_char_ev <= 2'h1;
    i_dac_line_model.rx_rise(0);
    expect_ready("rx ready", 10, 14);
    $display("test ready done");
    report_and_stop;
  end
endmodule
`default_nettype wire
